/* File: verilog/ccu_pkg.sv */
package ccu_pkg;
    // timer range
    localparam logic [15:0] TMR_ZERO = 16'h0000;
    localparam logic [15:0] TMR_MAX  = 16'hFFFF;
    localparam logic [15:0] TMR_ONE  = 16'h0001;
    // register byte offsets (low address byte)
    localparam logic [7:0]  OFF_TMR  = 8'h00;
    localparam logic [7:0]  OFF_FLAG = 8'h04;
    localparam logic [7:0]  OFF_IEN  = 8'h08;
    localparam logic [7:0]  OFF_TCTL = 8'h0C;
    // unit pages: 0x10 ctrl0, 0x14 val0, 0x18 ctrl1, 0x1C val1
    localparam logic [3:0]  UNIT_PAGE    = 4'h1;
    localparam int          UNIT_SEL_BIT = 3;
    localparam int          UNIT_VAL_BIT = 2;
    // field positions
    localparam int          FLG_OVF   = 0;
    localparam int          FLG_UNIT  = 1;
    localparam int          IEN_OVF   = 0;
    localparam int          TCTL_RUN  = 0;
    localparam int          TCTL_EXT  = 1;
    localparam int          NUNITS    = 2;
    localparam int          ADC_UNIT  = 1;
    // capture prescaler terminal counts
    localparam logic [3:0]  PRE_4     = 4'h3;
    localparam logic [3:0]  PRE_16    = 4'hF;
    localparam logic [3:0]  PRE_ZERO  = 4'h0;
    localparam logic [3:0]  PRE_ONE   = 4'h1;
    localparam logic [1:0]  PWM_SEL   = 2'b11;
    // mode field encodings
    typedef enum logic [3:0] {
        M_OFF   = 4'h0,
        M_TOG   = 4'h2,
        M_CAPF  = 4'h4,
        M_CAPR  = 4'h5,
        M_CAP4  = 4'h6,
        M_CAP16 = 4'h7,
        M_CLO   = 4'h8,
        M_CHI   = 4'h9,
        M_SWI   = 4'hA,
        M_SPEV  = 4'hB
    } ccu_mode_t;
    // bus phase states, gray along idle-wait-read
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_WR   = 2'b01,
        S_RW   = 2'b10,
        S_RD   = 2'b11
    } ccu_ph_t;
endpackage : ccu_pkg

/* File: verilog/ccu_unit_if.sv */
`timescale 1ns/1ps
interface ccu_unit_if;
    logic [7:0]  ctrl;
    logic        wr_val;
    logic [15:0] wdata;
    logic [15:0] tmr;
    logic        pin_in;
    logic [15:0] val;
    logic        irq_set;
    logic        spev;
    logic        pin_out;
    logic        pin_oe;
    modport hub  (output ctrl, wr_val, wdata, tmr, pin_in,
                  input val, irq_set, spev, pin_out, pin_oe);
    modport unit (input ctrl, wr_val, wdata, tmr, pin_in,
                  output val, irq_set, spev, pin_out, pin_oe);
endinterface : ccu_unit_if

/* File: verilog/ccu_unit.sv */
`timescale 1ns/1ps
module ccu_unit (
    input  wire logic clk,    // system clock
    input  wire logic resetn, // async reset, low
    ccu_unit_if.unit  u       // hub side
);
    typedef struct packed {
        logic [15:0] val;
        logic        pin;
        logic        oe;
        logic        prev_in;
        logic [3:0]  pre;
        logic [3:0]  mode_prev;
        logic        eq_prev;
    } ccu_unit_st_t;

    ccu_unit_st_t s_r, s_nxt;
    logic [3:0]   mode;
    logic         ent, rise, fall, hit, irq, spev;

    ////////////////////////////////////////////////////////////////
    // mode behaviour
    always_comb
    begin
        s_nxt = s_r;
        irq = 1'b0;
        spev = 1'b0;
        mode = u.ctrl[3:0];
        ent = mode != s_r.mode_prev;
        rise = u.pin_in & ~s_r.prev_in;
        fall = ~u.pin_in & s_r.prev_in;
        hit = (u.tmr == s_r.val) & ~s_r.eq_prev;
        s_nxt.mode_prev = mode;
        s_nxt.prev_in = u.pin_in;
        s_nxt.eq_prev = u.tmr == s_r.val;
        if (ent)
        begin
            s_nxt.pre = ccu_pkg::PRE_ZERO;
        end
        unique case (mode)
            ccu_pkg::M_OFF:
            begin
                s_nxt.pin = 1'b0;
                s_nxt.oe = 1'b0;
                s_nxt.pre = ccu_pkg::PRE_ZERO;
                s_nxt.eq_prev = 1'b0;
            end
            ccu_pkg::M_TOG:
            begin
                s_nxt.oe = 1'b1;
                if (hit)
                begin
                    s_nxt.pin = ~s_r.pin;
                    irq = 1'b1;
                end
            end
            ccu_pkg::M_CAPF, ccu_pkg::M_CAPR:
            begin
                s_nxt.oe = 1'b0;
                if (mode[0] ? rise : fall)
                begin
                    s_nxt.val = u.tmr;
                    irq = 1'b1;
                end
            end
            ccu_pkg::M_CAP4, ccu_pkg::M_CAP16:
            begin
                s_nxt.oe = 1'b0;
                if (rise && !ent)
                begin
                    // every 4th or 16th rising edge
                    if (s_r.pre == (mode[0] ? ccu_pkg::PRE_16 : ccu_pkg::PRE_4))
                    begin
                        s_nxt.pre = ccu_pkg::PRE_ZERO;
                        s_nxt.val = u.tmr;
                        irq = 1'b1;
                    end
                    else
                    begin
                        s_nxt.pre = s_r.pre + ccu_pkg::PRE_ONE;
                    end
                end
            end
            ccu_pkg::M_CLO, ccu_pkg::M_CHI:
            begin
                s_nxt.oe = 1'b1;
                if (ent)
                begin
                    s_nxt.pin = mode[0];
                end
                else if (hit)
                begin
                    s_nxt.pin = ~mode[0];
                    irq = 1'b1;
                end
            end
            ccu_pkg::M_SWI:
            begin
                s_nxt.oe = 1'b0;
                irq = hit;
            end
            ccu_pkg::M_SPEV:
            begin
                s_nxt.oe = 1'b0;
                irq = hit;
                spev = hit;
            end
            default:
            begin
                if (mode[3:2] == ccu_pkg::PWM_SEL)
                begin
                    // 10-bit duty from value low byte and control bits 5-4
                    s_nxt.oe = 1'b1;
                    s_nxt.pin = u.tmr[9:0] < {s_r.val[7:0], u.ctrl[5:4]};
                end
                else
                begin
                    s_nxt.oe = 1'b0; // reserved codes stay idle
                end
            end
        endcase
        // software write to the value register wins over a capture
        if (u.wr_val)
        begin
            s_nxt.val = u.wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign u.val = s_r.val;
    assign u.irq_set = irq;
    assign u.spev = spev;
    assign u.pin_out = s_r.pin;
    assign u.pin_oe = s_r.oe;

    ////////////////////////////////////////////////////////////////
    // checks
    a_toggle_pin: assert property (@(posedge clk) disable iff (!resetn)
        (mode == ccu_pkg::M_TOG && hit && $past(mode) == ccu_pkg::M_TOG)
        |=> u.pin_out != $past(u.pin_out))
        else $error("toggle mode did not flip pin");
    a_capture_val: assert property (@(posedge clk) disable iff (!resetn)
        (mode == ccu_pkg::M_CAPR && rise && !u.wr_val) |=> u.val == $past(u.tmr))
        else $error("capture lost timer value");
    a_off_idle: assert property (@(posedge clk) disable iff (!resetn)
        (mode == ccu_pkg::M_OFF) |=> !u.pin_out && !u.pin_oe)
        else $error("disabled unit still drives");
endmodule : ccu_unit

/* File: verilog/ccu_top.sv */
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ccu_top (
    input  wire logic        clk,        // 100 MHz clock
    input  wire logic        resetn,     // async reset, low
    input  wire logic        hsel,       // slave select
    input  wire logic [31:0] haddr,      // byte address
    input  wire logic [1:0]  htrans,     // transfer type
    input  wire logic        hwrite,     // write when high
    input  wire logic [2:0]  hsize,      // word only
    input  wire logic [31:0] hwdata,     // write data
    input  wire logic        hready,     // bus ready in
    output logic      [31:0] hrdata,     // read data
    output logic             hreadyout,  // slave ready
    output logic             hresp,      // always okay
    input  wire logic [1:0]  ccp_pin_i,  // unit pin levels
    output logic      [1:0]  ccp_pin_o,  // unit pin drive
    output logic      [1:0]  ccp_pin_oe, // unit pin enable
    input  wire logic        tclk_pin,   // external count pin
    input  wire logic        adc_enable, // converter enabled
    output logic             adc_start,  // conversion start pulse
    output logic             timer_irq   // overflow interrupt
);
    typedef struct packed {
        logic [15:0]     tmr;
        logic            ovf;
        logic            ovf_en;
        logic [1:0]      tctl;
        logic [1:0]      uflag;
        logic [1:0][5:0] ctrl;
        logic            adc_go;
        logic [1:0]      sy1;
        logic [1:0]      sy2;
        logic            t1;
        logic            t2;
        logic            t3;
        ccu_pkg::ccu_ph_t ph;
        logic [7:0]      addr;
        logic [31:0]     rdata;
    } ccu_top_st_t;

    ccu_top_st_t s_r, s_nxt;
    ccu_unit_if  uif[ccu_pkg::NUNITS]();
    logic [1:0]  u_irq, u_spev;
    logic [15:0] u_val[ccu_pkg::NUNITS];
    logic        wr, tick, wrap, accept, upage, rsel;

    ////////////////////////////////////////////////////////////////
    // compare/capture units
    genvar g;
    generate
        for (g = 0; g < ccu_pkg::NUNITS; g++)
        begin : g_unit
            ccu_unit u_unit (
                .clk    (clk),
                .resetn (resetn),
                .u      (uif[g])
            );
            // bits 7-6 never reach the unit
            assign uif[g].ctrl = {2'b00, s_r.ctrl[g]};
            assign uif[g].wr_val = wr && upage && s_r.addr[ccu_pkg::UNIT_SEL_BIT] == 1'(g)
                                   && s_r.addr[ccu_pkg::UNIT_VAL_BIT];
            assign uif[g].wdata = hwdata[15:0];
            assign uif[g].tmr = s_r.tmr;
            assign uif[g].pin_in = s_r.sy2[g];
            assign u_val[g] = uif[g].val;
            assign u_irq[g] = uif[g].irq_set;
            assign u_spev[g] = uif[g].spev;
            assign ccp_pin_o[g] = uif[g].pin_out;
            assign ccp_pin_oe[g] = uif[g].pin_oe;
        end
    endgenerate

    assign wr = s_r.ph == ccu_pkg::S_WR;
    assign upage = s_r.addr[7:4] == ccu_pkg::UNIT_PAGE;
    assign rsel = s_r.addr[ccu_pkg::UNIT_SEL_BIT];
    assign accept = hsel && htrans[1] && hready;
    // timer counts on the clock, or on synchronised pin rises
    assign tick = s_r.tctl[ccu_pkg::TCTL_RUN]
                  && (!s_r.tctl[ccu_pkg::TCTL_EXT] || (s_r.t2 && !s_r.t3));
    assign wrap = tick && s_r.tmr == ccu_pkg::TMR_MAX && !(|u_spev);

    ////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        s_nxt = s_r;
        // two-flop synchronisers, third flop for edge detect
        s_nxt.sy1 = ccp_pin_i;
        s_nxt.sy2 = s_r.sy1;
        s_nxt.t1 = tclk_pin;
        s_nxt.t2 = s_r.t1;
        s_nxt.t3 = s_r.t2;
        // register writes; flag clears come first so sets win
        if (wr)
        begin
            if (s_r.addr == ccu_pkg::OFF_FLAG)
            begin
                s_nxt.ovf = s_r.ovf & ~hwdata[ccu_pkg::FLG_OVF];
                s_nxt.uflag = s_r.uflag & ~hwdata[ccu_pkg::FLG_UNIT +: 2];
            end
            if (s_r.addr == ccu_pkg::OFF_IEN)
            begin
                s_nxt.ovf_en = hwdata[ccu_pkg::IEN_OVF];
            end
            if (s_r.addr == ccu_pkg::OFF_TCTL)
            begin
                s_nxt.tctl = hwdata[1:0];
            end
            if (upage && !s_r.addr[ccu_pkg::UNIT_VAL_BIT])
            begin
                s_nxt.ctrl[rsel] = hwdata[5:0];
            end
        end
        // timer: special event reset, else count and wrap
        if (|u_spev)
        begin
            s_nxt.tmr = ccu_pkg::TMR_ZERO;
        end
        else if (tick)
        begin
            s_nxt.tmr = s_r.tmr + ccu_pkg::TMR_ONE;
        end
        if (wrap)
        begin
            s_nxt.ovf = 1'b1;
        end
        s_nxt.uflag = s_nxt.uflag | u_irq;
        s_nxt.adc_go = u_spev[ccu_pkg::ADC_UNIT] && adc_enable;
        // a coinciding software write wins over the reset
        if (wr && s_r.addr == ccu_pkg::OFF_TMR)
        begin
            s_nxt.tmr = hwdata[15:0];
        end
        // bus phases: writes zero wait, reads one wait
        if (accept)
        begin
            s_nxt.addr = haddr[7:0];
            s_nxt.ph = hwrite ? ccu_pkg::S_WR : ccu_pkg::S_RW;
        end
        else if (s_r.ph == ccu_pkg::S_RW)
        begin
            s_nxt.ph = ccu_pkg::S_RD;
        end
        else
        begin
            s_nxt.ph = ccu_pkg::S_IDLE;
        end
        // read data sampled during the wait cycle
        if (s_r.ph == ccu_pkg::S_RW)
        begin
            s_nxt.rdata = '0;
            if (upage)
            begin
                s_nxt.rdata[15:0] = s_r.addr[ccu_pkg::UNIT_VAL_BIT] ? u_val[rsel]
                                    : {10'h000, s_r.ctrl[rsel]};
            end
            else if (s_r.addr == ccu_pkg::OFF_TMR)
            begin
                s_nxt.rdata[15:0] = s_r.tmr;
            end
            else if (s_r.addr == ccu_pkg::OFF_FLAG)
            begin
                s_nxt.rdata[2:0] = {s_r.uflag, s_r.ovf};
            end
            else if (s_r.addr == ccu_pkg::OFF_IEN)
            begin
                s_nxt.rdata[0] = s_r.ovf_en;
            end
            else if (s_r.addr == ccu_pkg::OFF_TCTL)
            begin
                s_nxt.rdata[1:0] = s_r.tctl;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    assign hrdata = s_r.rdata;
    assign hreadyout = s_r.ph != ccu_pkg::S_RW;
    assign hresp = 1'b0;
    assign adc_start = s_r.adc_go;
    assign timer_irq = s_r.ovf & s_r.ovf_en;

    ////////////////////////////////////////////////////////////////
    // checks
    a_timer_wrap: assert property (@(posedge clk) disable iff (!resetn)
        (wrap && !wr) |=> s_r.tmr == ccu_pkg::TMR_ZERO && s_r.ovf)
        else $error("wrap did not zero timer and set flag");
    a_irq_gate: assert property (@(posedge clk) disable iff (!resetn)
        (s_r.ovf && !s_r.ovf_en) |-> !timer_irq)
        else $error("overflow interrupt raised while disabled");
    a_adc_start: assert property (@(posedge clk) disable iff (!resetn)
        adc_start |-> $past(u_spev[ccu_pkg::ADC_UNIT] && adc_enable))
        else $error("conversion start without second unit event");
    a_write_wins: assert property (@(posedge clk) disable iff (!resetn)
        (wr && s_r.addr == ccu_pkg::OFF_TMR && |u_spev) |=> s_r.tmr == $past(hwdata[15:0]))
        else $error("special event beat timer write");
    a_event_reset: assert property (@(posedge clk) disable iff (!resetn)
        (|u_spev && !(wr && s_r.addr == ccu_pkg::OFF_TMR)) |=> s_r.tmr == ccu_pkg::TMR_ZERO)
        else $error("special event did not reset timer");
    a_event_noflag: assert property (@(posedge clk) disable iff (!resetn)
        (|u_spev && !s_r.ovf) |=> !s_r.ovf)
        else $error("special event set overflow flag");
    a_ctrl_zero: assert property (@(posedge clk) disable iff (!resetn)
        (s_r.ph == ccu_pkg::S_RD && upage && !s_r.addr[ccu_pkg::UNIT_VAL_BIT])
        |-> hrdata[7:6] == 2'b00)
        else $error("control bits 7-6 not zero");
    a_flag_sticky: assert property (@(posedge clk) disable iff (!resetn)
        (s_r.ovf && !(wr && s_r.addr == ccu_pkg::OFF_FLAG)) |=> s_r.ovf)
        else $error("overflow flag dropped without clear");
endmodule : ccu_top

/* File: test/ccu_pin_adc_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module ccu_pin_adc_model (
    input  wire logic       clk,        // system clock
    input  wire logic [1:0] pin_o,      // unit pin drive
    input  wire logic [1:0] pin_oe,     // unit pin enable
    output logic      [1:0] pin_i,      // resolved pin level
    output logic            adc_enable, // converter enabled
    input  wire logic       adc_start,  // conversion start pulse
    output logic      [7:0] adc_cnt     // starts seen
);
    logic [1:0] drv_r = 2'b00;
    initial adc_enable = 1'b0;
    initial adc_cnt = 8'h00;
    // unit drive wins over the external source
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & drv_r);
    // every start is counted so a start while disabled shows up
    always @(posedge clk)
    begin
        if (adc_start === 1'b1)
        begin
            adc_cnt <= adc_cnt + 8'h01;
        end
    end
    // one rise then one fall on a unit pin
    task automatic pulse(input int u);
        drv_r[u] <= 1'b1;
        repeat (6) @(posedge clk);
        drv_r[u] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : pulse
    task automatic set_adc(input logic e);
        adc_enable <= e;
    endtask : set_adc
endmodule : ccu_pin_adc_model

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic pin; logic [31:0] e; logic [31:0] m;} ccu_exp_t;
    localparam logic [3:0] CMP_M [4] = '{4'h2, 4'h8, 4'h9, 4'hA};
    localparam logic [31:0] CMP_I [4] = '{32'h4, 32'h4, 32'h5, 32'h0};
    localparam logic [31:0] CMP_A [4] = '{32'h5, 32'h5, 32'h4, 32'h0};
    localparam int CAP_N [4] = '{1, 1, 4, 16};
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        tclk_pin = 1'b0;
    logic        pin_chk = 1'b0;
    logic        rd_dph = 1'b0;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, adc_enable, adc_start, timer_irq;
    wire  [1:0]  pin_i, pin_o, pin_oe;
    wire  [7:0]  adc_cnt;
    wire  [31:0] stat = {16'h0, adc_cnt, 1'b0, hresp, adc_start, timer_irq, pin_oe,
                         pin_o & pin_oe};
    ccu_exp_t    q[$];
    int          err_total = 0;
    int          cmp_count = 0;
    always #5 clk = ~clk;
    ccu_top i_dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ccp_pin_i(pin_i), .ccp_pin_o(pin_o),
        .ccp_pin_oe(pin_oe), .tclk_pin(tclk_pin), .adc_enable(adc_enable),
        .adc_start(adc_start), .timer_irq(timer_irq));
    ccu_pin_adc_model i_part (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i),
        .adc_enable(adc_enable), .adc_start(adc_start), .adc_cnt(adc_cnt));
    ////////////////////////////////////////////////////////////////////////////
    // watcher: oldest note against read data or pin status
    always @(posedge clk)
    begin
        ccu_exp_t x;
        logic [31:0] g;
        if (pin_chk || (rd_dph && hreadyout === 1'b1))
        begin
            x = (q.size() > 0) ? q.pop_front() : '{1'b0, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
            g = x.pin ? stat : hrdata;
            cmp_count++;
            if ((g & x.m) !== (x.e & x.m))
            begin
                err_total++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, g & x.m, x.e & x.m);
            end
        end
        if (hsel && htrans[1] && hreadyout) rd_dph = !hwrite;
        else if (hreadyout) rd_dph = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            err_total++;
            final_report;
        end
    endtask : wait_rdy
    // one single ahb transfer, held until ready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        q.push_back('{1'b0, e, m});
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic chk(input logic [31:0] e, input logic [31:0] m);
        q.push_back('{1'b1, e, m});
        pin_chk <= 1'b1;
        @(posedge clk);
        pin_chk <= 1'b0;
    endtask : chk
    task automatic run(input logic [31:0] t, input int c);
        wr(ccu_pkg::OFF_TCTL, t);
        repeat (c) @(posedge clk);
        wr(ccu_pkg::OFF_TCTL, 32'h0);
    endtask : run
    ////////////////////////////////////////////////////////////////////////////
    // watchdog
    initial
    begin
        repeat (90000) @(posedge clk);
        err_total++;
        final_report;
    end
    // main sequence; modes 0001 and 0011 are never written
    initial
    begin
        int n;
        logic [15:0] v;
        logic [7:0] c0;
        void'($urandom(32'h2430489B));
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(ccu_pkg::OFF_TMR, 32'h0, 32'hFFFF_FFFF);
        rd(8'h10, 32'h0, 32'hFFFF_FFFF);
        chk(32'h0, 32'hFFFF);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0, 32'hFFFF_FFFF);
        wr(8'h10, 32'hFFFF_FFF0);
        rd(8'h10, 32'h30, 32'hFFFF_FFFF);
        wr(8'h10, 32'h0);
        $display("test registers done");
        wr(ccu_pkg::OFF_TMR, 32'hFFF0);
        run(32'h1, 40);
        rd(ccu_pkg::OFF_FLAG, 32'h1, 32'h1);
        rd(ccu_pkg::OFF_TMR, 32'h0, 32'hFF00);
        chk(32'h0, 32'h10);
        wr(ccu_pkg::OFF_IEN, 32'h1);
        chk(32'h10, 32'h10);
        wr(ccu_pkg::OFF_FLAG, 32'h1);
        chk(32'h0, 32'h10);
        wr(ccu_pkg::OFF_IEN, 32'h0);
        wr(ccu_pkg::OFF_TMR, 32'h0);
        wr(ccu_pkg::OFF_TCTL, 32'h3);
        repeat (5)
        begin
            tclk_pin <= 1'b1;
            repeat (4) @(posedge clk);
            tclk_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        wr(ccu_pkg::OFF_TCTL, 32'h0);
        rd(ccu_pkg::OFF_TMR, 32'h5, 32'hFFFF);
        $display("test timer done");
        for (int i = 0; i < 4; i++)
        begin
            wr(ccu_pkg::OFF_TMR, 32'h0);
            wr(8'h14, 32'h10);
            wr(8'h10, {28'h0, CMP_M[i]});
            // the entry level reaches the pin flop one edge after the write lands
            @(posedge clk);
            chk(CMP_I[i], 32'h5);
            run(32'h1, 40);
            chk(CMP_A[i], 32'h5);
            rd(ccu_pkg::OFF_FLAG, 32'h2, 32'h2);
            wr(ccu_pkg::OFF_FLAG, 32'h7);
            wr(8'h10, 32'h0);
            @(posedge clk);
            chk(32'h0, 32'h5);
        end
        $display("test compare done");
        for (int i = 0; i < 4; i++)
        begin
            v = 16'($urandom) | 16'h0001;
            wr(ccu_pkg::OFF_TMR, {16'h0, v});
            wr(8'h14, 32'h0);
            wr(8'h10, {28'h0, 4'h4 + 4'(i)});
            for (n = 1; n < CAP_N[i]; n++) i_part.pulse(0);
            rd(8'h14, 32'h0, 32'hFFFF);
            rd(ccu_pkg::OFF_FLAG, 32'h0, 32'h2);
            i_part.pulse(0);
            rd(8'h14, {16'h0, v}, 32'hFFFF);
            rd(ccu_pkg::OFF_FLAG, 32'h2, 32'h2);
            wr(ccu_pkg::OFF_FLAG, 32'h7);
            wr(8'h10, 32'h0);
        end
        $display("test capture done");
        for (int i = 0; i < 4; i++)
        begin
            wr(ccu_pkg::OFF_TMR, 32'h6);
            wr(8'h14, 32'h1);
            wr(8'h10, {28'h3, 4'hC + 4'(i)});
            repeat (2) @(posedge clk);
            chk(32'h5, 32'h5);
            wr(ccu_pkg::OFF_TMR, 32'h7);
            repeat (2) @(posedge clk);
            chk(32'h4, 32'h5);
            wr(8'h10, 32'h0);
        end
        $display("test pwm done");
        i_part.set_adc(1'b1);
        wr(ccu_pkg::OFF_TMR, 32'h0);
        wr(8'h1C, 32'h20);
        wr(8'h18, 32'hB);
        wr(ccu_pkg::OFF_TCTL, 32'h1);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (adc_start !== 1'b1 && n < 200);
        if (adc_start !== 1'b1)
        begin
            err_total++;
            final_report;
        end
        c0 = adc_cnt;
        // timer write lands in the match cycle, so the next period starts at 0x10
        repeat (30) @(posedge clk);
        wr(ccu_pkg::OFF_TMR, 32'h10);
        repeat (116) @(posedge clk);
        chk({16'h0, c0 + 8'h05, 8'h20}, 32'hFF20);
        rd(ccu_pkg::OFF_FLAG, 32'h4, 32'h5);
        i_part.set_adc(1'b0);
        repeat (3) @(posedge clk);
        c0 = adc_cnt;
        repeat (100) @(posedge clk);
        chk({16'h0, c0, 8'h00}, 32'hFF20);
        wr(ccu_pkg::OFF_TCTL, 32'h0);
        wr(8'h18, 32'h0);
        $display("test special event done");
        final_report;
    end
endmodule : tb
